// [inc/isa_dma_pkg.sv]
// Purpose: shared constants and types for the legacy dma controller pair
// Assumes: byte-wide io port access, 12-bit io address
// Notes: offsets are io port numbers, not byte lanes of a wider bus
package isa_dma_pkg;
  // low controller ports, channels 3..0
  localparam logic [11:0] LO_CHAN_LAST = 12'h007;
  localparam logic [11:0] LO_STATUS_CMD = 12'h008;
  localparam logic [11:0] LO_SW_REQ = 12'h009;
  localparam logic [11:0] LO_SINGLE_MASK = 12'h00a;
  localparam logic [11:0] LO_MODE = 12'h00b;
  localparam logic [11:0] LO_CLR_PTR = 12'h00c;
  localparam logic [11:0] LO_MASTER_CLR = 12'h00d;
  localparam logic [11:0] LO_CLR_MASKS = 12'h00e;
  localparam logic [11:0] LO_WR_MASKS = 12'h00f;
  // high controller ports, channels 7..4
  localparam logic [7:0] HI_CHAN_PAGE = 8'h0c;
  localparam logic [11:0] HI_STATUS_CMD = 12'h0d0;
  localparam logic [11:0] HI_SW_REQ = 12'h0d2;
  localparam logic [11:0] HI_SINGLE_MASK = 12'h0d4;
  localparam logic [11:0] HI_MODE = 12'h0d6;
  localparam logic [11:0] HI_CLR_MASKS = 12'h0dc;
  // command register bit positions
  localparam int CMD_GRANT_HIGH = 7;
  localparam int CMD_REQ_LOW = 6;
  localparam int CMD_EXT_WRITE = 5;
  localparam int CMD_ROTATE = 4;
  localparam int CMD_COMPRESS = 3;
  localparam int CMD_ENABLE = 2;
  // request / mask / mode write fields
  localparam int SEL_SET_BIT = 2;
  localparam int MODE_DECR = 5;
  localparam int MODE_AUTO = 4;
  // reset values
  localparam logic [7:0] CMD_RESET = 8'h00;
  localparam logic [5:0] MODE_RESET = 6'h00;
  localparam logic [3:0] MASK_RESET = 4'hf;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  // idle cycles between transfers in normal timing
  localparam logic [1:0] GAP_NORMAL = 2'h1;
  // transfer fifo shape: {chan, to_memory, address}
  localparam int FIFO_WIDTH = 19;
  localparam int FIFO_DEPTH = 8;
  typedef enum logic [1:0]
  {
    STYLE_DEMAND = 2'b00,
    STYLE_SINGLE = 2'b01,
    STYLE_BLOCK = 2'b10,
    STYLE_CASCADE = 2'b11
  } style_t;
  typedef enum logic [1:0]
  {
    KIND_VERIFY = 2'b00,
    KIND_WRITE = 2'b01,
    KIND_READ = 2'b10,
    KIND_RESERVED = 2'b11
  } kind_t;
endpackage

// [inc/dma_fifo_if.sv]
// Purpose: carrier between the dma engine and its transfer fifo
// Assumes: single clock, valid/ready on both sides
// Notes: user side fills and drains, store side is the fifo itself
`timescale 1ns/100ps
interface dma_fifo_if #(parameter int WIDTH = 19);
  logic in_valid;
  logic in_ready;
  logic [WIDTH-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [WIDTH-1:0] out_data;
  modport user
  (
    output in_valid, in_data, out_ready,
    input in_ready, out_valid, out_data
  );
  modport store
  (
    input in_valid, in_data, out_ready,
    output in_ready, out_valid, out_data
  );
endinterface

// [rtl/dma_xfer_fifo.sv]
// Purpose: small synchronous fifo for issued transfers
// Assumes: one clock, push and pop may happen in the same cycle
// Notes: read data come straight from the storage flops
`timescale 1ns/100ps
module dma_xfer_fifo
#(
  parameter int WIDTH = 19,
  parameter int DEPTH = 8
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // both sides
  dma_fifo_if.store port
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic push;
  logic pop;

  ////////////////////////////////////////////////////////////////////////
  // full when pointers differ only in the wrap bit
  assign port.in_ready = (wr_ptr ^ rd_ptr) != {1'b1, {AW{1'b0}}};
  assign port.out_valid = wr_ptr != rd_ptr;
  assign port.out_data = mem[rd_ptr[AW-1:0]];
  assign push = port.in_valid && port.in_ready;
  assign pop = port.out_valid && port.out_ready;

  // pointers
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
    end
  end

  // storage, no reset needed since empty guards it
  always_ff @(posedge clk_i)
  begin
    if (push)
      mem[wr_ptr[AW-1:0]] <= port.in_data;
  end
endmodule

// [rtl/isa_dma_ctrl.sv]
// Purpose: legacy dma controller pair, io registers and channel engine
// Assumes: one-cycle io_wr_i / io_rd_i strobes per byte access
// Notes: only the low controller moves data; channel 4 is cascade only
// Behaviour
// - registers live at io ports 000h..00fh and 0c0h..0dch, accessed one byte each
// - address and count are 16 bits, written low byte then high byte
// - clear byte pointer write makes next low controller access hit the low byte
// - low status read gives requests in 7..4, counts exhausted in 3..0
// - low command write sets polarities, write style, priority, timing, enable
// - command bit 7 low gives active low grant, high gives active high
// - software request port sets or clears chosen channel request
// - single mask port masks or unmasks one channel; masked never picked, one in service ends after its next step, a cascade one at once
// - mode port stores mode for the chosen channel only
// - mode bits 7:6 pick demand, single, block or cascade transfers
// - mode bit 5 picks increment or decrement of the current address
// - auto-init reloads address and count when the count runs out
// - type bits: verify moves nothing, write to memory, read from memory
// - master clear returns the low controller to reset, except its address and count words and the transfers queued in the fifo
// - clear mask port unmasks all four low channels
// - write mask port loads all four low masks at once
// - channel 4 address and count exist but never drive a transfer
// - channels 5 to 7 accept control writes yet move no data
// - high status gives software requests 7..5 in 7..5, zeros in 4..0
// - high command port has the same layout, for channels 7..4
`timescale 1ns/100ps
module isa_dma_ctrl
  import isa_dma_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // io port access
  input wire logic [11:0] io_addr_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [7:0] io_wdata_i,
  output logic [7:0] io_rdata_o,
  // peripheral handshake
  input wire logic [3:0] transfer_request_line_i,
  output logic [3:0] transfer_grant_o,
  output logic count_exhausted_o,
  output logic extended_write_o,
  // issued transfers
  output logic xfer_valid_o,
  input wire logic xfer_ready_i,
  output logic [15:0] xfer_addr_o,
  output logic [1:0] xfer_chan_o,
  output logic xfer_to_memory_o
);
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_MOVE = 2'b01,
    ST_GAP = 2'b11
  } state_t;

  // pick first requesting channel, searching upward from start
  function automatic logic [1:0] pick(input logic [3:0] req,
                                      input logic [1:0] start);
    logic [1:0] idx;
    logic [1:0] found;
    found = start;
    for (int i = 3; i >= 0; i--)
    begin
      idx = start + 2'(i);
      if (req[idx])
        found = idx;
    end
    return found;
  endfunction

  // select one byte of a word by the byte pointer
  function automatic logic [7:0] byte_of(input logic [15:0] w,
                                         input logic hi);
    return hi ? w[15:8] : w[7:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // state
  logic [3:0] req_meta;
  logic [3:0] req_sync;
  logic [7:0] lo_cmd;
  logic [7:0] hi_cmd;
  logic [3:0] lo_mask;
  logic [3:0] hi_mask;
  logic [3:0] lo_sw_req;
  logic [3:1] hi_sw_req;
  logic [3:0] lo_tc;
  logic [5:0] lo_mode [4];
  logic [5:0] hi_mode [4];
  logic [15:0] base_addr [4];
  logic [15:0] base_count [4];
  logic [15:0] cur_addr [4];
  logic [15:0] cur_count [4];
  logic [15:0] ch4_addr;
  logic [15:0] ch4_count;
  logic lo_ptr;
  logic hi_ptr;
  state_t state;
  logic [1:0] active;
  logic [1:0] last_served;
  logic [1:0] gap_cnt;
  logic keep_going;
  logic [7:0] io_rdata;
  logic tc_pulse;
  // declared early, the engine looks at its ready
  dma_fifo_if #(.WIDTH(FIFO_WIDTH)) fifo ();

  ////////////////////////////////////////////////////////////////////////
  // decode of the io strobes
  logic lo_word_hit;
  logic hi_word_hit;
  logic lo_word_wr;
  logic hi_word_wr;
  logic lo_cmd_wr;
  logic master_clr;
  logic lo_status_rd;
  logic [1:0] lo_word_chan;
  logic [1:0] hi_word_chan;
  assign lo_word_hit = io_addr_i <= LO_CHAN_LAST;
  assign hi_word_hit = io_addr_i[11:4] == HI_CHAN_PAGE && !io_addr_i[0];
  assign lo_word_chan = io_addr_i[2:1];
  assign hi_word_chan = io_addr_i[3:2];
  assign lo_word_wr = io_wr_i && lo_word_hit;
  assign hi_word_wr = io_wr_i && hi_word_hit;
  assign lo_cmd_wr = io_wr_i && io_addr_i == LO_STATUS_CMD;
  assign master_clr = io_wr_i && io_addr_i == LO_MASTER_CLR;
  assign lo_status_rd = io_rd_i && io_addr_i == LO_STATUS_CMD;

  // request pins cross into clk_i before anyone looks at them
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      req_meta <= 4'h0;
      req_sync <= 4'h0;
    end
    else
    begin
      req_meta <= transfer_request_line_i;
      req_sync <= req_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // engine view of requests
  logic [3:0] hw_req;
  logic [3:0] pending;
  logic [3:0] eligible;
  logic [1:0] style;
  logic [1:0] kind;
  logic moves_data;
  logic can_step;
  logic step;
  logic at_tc;
  logic finish;
  assign hw_req = req_sync ^ {4{lo_cmd[CMD_REQ_LOW]}};
  assign pending = hw_req | lo_sw_req;
  // masked channels never reach the arbiter
  assign eligible = pending & ~lo_mask & {4{lo_cmd[CMD_ENABLE]}};
  assign style = lo_mode[active][5:4];
  assign kind = lo_mode[active][1:0];
  // verify and the reserved code touch no data path
  assign moves_data = kind == KIND_WRITE || kind == KIND_READ;
  assign can_step = !moves_data || fifo.in_ready;
  assign step = state == ST_MOVE && style != STYLE_CASCADE && can_step;
  assign at_tc = cur_count[active] == WORD_RESET;
  // when to hand the bus back after this step
  always_comb
  begin
    unique case (style)
      STYLE_SINGLE: finish = 1'b1;
      STYLE_BLOCK: finish = at_tc;
      STYLE_DEMAND: finish = at_tc || !hw_req[active];
      STYLE_CASCADE: finish = 1'b1;
    endcase
    if (lo_mask[active] || !lo_cmd[CMD_ENABLE])
      finish = 1'b1;
  end

  // arbiter and service sequence
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state <= ST_IDLE;
      active <= 2'h0;
      last_served <= 2'h3;
      gap_cnt <= 2'h0;
      keep_going <= 1'b0;
    end
    else if (master_clr)
    begin
      state <= ST_IDLE;
      active <= 2'h0;
      last_served <= 2'h3;
      gap_cnt <= 2'h0;
      keep_going <= 1'b0;
    end
    else
    begin
      unique case (state)
        ST_IDLE:
          if (|eligible)
          begin
            // rotating starts after the last served channel
            active <= pick(eligible, lo_cmd[CMD_ROTATE] ?
                           last_served + 2'h1 : 2'h0);
            state <= ST_MOVE;
          end
        ST_MOVE:
          if (style == STYLE_CASCADE)
          begin
            // grant simply follows the request, no cycles of our own
            if (!eligible[active])
            begin
              last_served <= active;
              state <= ST_IDLE;
            end
          end
          else if (step)
          begin
            keep_going <= !finish;
            gap_cnt <= GAP_NORMAL;
            if (finish)
              last_served <= active;
            if (lo_cmd[CMD_COMPRESS])
              state <= finish ? ST_IDLE : ST_MOVE;
            else
              state <= ST_GAP;
          end
        ST_GAP:
          if (gap_cnt <= 2'h1)
            state <= keep_going ? ST_MOVE : ST_IDLE;
          else
            gap_cnt <= gap_cnt - 2'h1;
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // low controller address and count words
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      for (int i = 0; i < 4; i++)
      begin
        base_addr[i] <= WORD_RESET;
        base_count[i] <= WORD_RESET;
        cur_addr[i] <= WORD_RESET;
        cur_count[i] <= WORD_RESET;
      end
    end
    else if (lo_word_wr)
    begin
      // low byte first, then high byte, into base and current
      if (io_addr_i[0])
      begin
        if (lo_ptr)
          base_count[lo_word_chan][15:8] <= io_wdata_i;
        else
          base_count[lo_word_chan][7:0] <= io_wdata_i;
        if (lo_ptr)
          cur_count[lo_word_chan][15:8] <= io_wdata_i;
        else
          cur_count[lo_word_chan][7:0] <= io_wdata_i;
      end
      else
      begin
        if (lo_ptr)
          base_addr[lo_word_chan][15:8] <= io_wdata_i;
        else
          base_addr[lo_word_chan][7:0] <= io_wdata_i;
        if (lo_ptr)
          cur_addr[lo_word_chan][15:8] <= io_wdata_i;
        else
          cur_addr[lo_word_chan][7:0] <= io_wdata_i;
      end
    end
    else if (step)
    begin
      // stored mode drops the two select bits, so fields sit 2 lower
      if (at_tc && lo_mode[active][MODE_AUTO - 2])
      begin
        cur_addr[active] <= base_addr[active];
        cur_count[active] <= base_count[active];
      end
      else
      begin
        // count wraps past zero, one more transfer than programmed
        cur_count[active] <= cur_count[active] - 16'h0001;
        if (lo_mode[active][MODE_DECR - 2])
          cur_addr[active] <= cur_addr[active] - 16'h0001;
        else
          cur_addr[active] <= cur_addr[active] + 16'h0001;
      end
    end
  end

  // byte pointers, one per controller
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      lo_ptr <= 1'b0;
      hi_ptr <= 1'b0;
    end
    else
    begin
      if ((io_wr_i && io_addr_i == LO_CLR_PTR) || master_clr)
        lo_ptr <= 1'b0;
      else if ((io_wr_i || io_rd_i) && lo_word_hit)
        lo_ptr <= !lo_ptr;
      if ((io_wr_i || io_rd_i) && hi_word_hit)
        hi_ptr <= !hi_ptr;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // low controller command, masks, modes, software requests
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      lo_cmd <= CMD_RESET;
      lo_mask <= MASK_RESET;
      lo_sw_req <= 4'h0;
      for (int i = 0; i < 4; i++)
        lo_mode[i] <= MODE_RESET;
    end
    else if (master_clr)
    begin
      lo_cmd <= CMD_RESET;
      lo_mask <= MASK_RESET;
      lo_sw_req <= 4'h0;
      for (int i = 0; i < 4; i++)
        lo_mode[i] <= MODE_RESET;
    end
    else
    begin
      if (lo_cmd_wr)
        lo_cmd <= io_wdata_i;
      if (io_wr_i && io_addr_i == LO_SINGLE_MASK)
        lo_mask[io_wdata_i[1:0]] <= io_wdata_i[SEL_SET_BIT];
      else if (io_wr_i && io_addr_i == LO_CLR_MASKS)
        lo_mask <= 4'h0;
      else if (io_wr_i && io_addr_i == LO_WR_MASKS)
        lo_mask <= io_wdata_i[3:0];
      if (io_wr_i && io_addr_i == LO_MODE)
        lo_mode[io_wdata_i[1:0]] <= io_wdata_i[7:2];
      // a software request is spent once its count runs out
      if (step && at_tc)
        lo_sw_req[active] <= 1'b0;
      if (io_wr_i && io_addr_i == LO_SW_REQ)
        lo_sw_req[io_wdata_i[1:0]] <= io_wdata_i[SEL_SET_BIT];
    end
  end

  // count exhausted flags; an expiry in the read cycle survives
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      lo_tc <= 4'h0;
      tc_pulse <= 1'b0;
    end
    else if (master_clr)
    begin
      lo_tc <= 4'h0;
      tc_pulse <= 1'b0;
    end
    else
    begin
      tc_pulse <= step && at_tc;
      for (int i = 0; i < 4; i++)
      begin
        if (step && at_tc && active == 2'(i))
          lo_tc[i] <= 1'b1;
        else if (lo_status_rd)
          lo_tc[i] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // high controller: channel 4 words kept, 5..7 accepted and dropped
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ch4_addr <= WORD_RESET;
      ch4_count <= WORD_RESET;
      hi_cmd <= CMD_RESET;
      hi_mask <= MASK_RESET;
      hi_sw_req <= 3'h0;
      for (int i = 0; i < 4; i++)
        hi_mode[i] <= MODE_RESET;
    end
    else
    begin
      if (hi_word_wr && hi_word_chan == 2'h0 && !io_addr_i[1])
      begin
        if (hi_ptr)
          ch4_addr[15:8] <= io_wdata_i;
        else
          ch4_addr[7:0] <= io_wdata_i;
      end
      if (hi_word_wr && hi_word_chan == 2'h0 && io_addr_i[1])
      begin
        if (hi_ptr)
          ch4_count[15:8] <= io_wdata_i;
        else
          ch4_count[7:0] <= io_wdata_i;
      end
      if (io_wr_i && io_addr_i == HI_STATUS_CMD)
        hi_cmd <= io_wdata_i;
      if (io_wr_i && io_addr_i == HI_SINGLE_MASK)
        hi_mask[io_wdata_i[1:0]] <= io_wdata_i[SEL_SET_BIT];
      else if (io_wr_i && io_addr_i == HI_CLR_MASKS)
        hi_mask <= 4'h0;
      if (io_wr_i && io_addr_i == HI_MODE)
        hi_mode[io_wdata_i[1:0]] <= io_wdata_i[7:2];
      // select 00 is illegal here and ignored
      if (io_wr_i && io_addr_i == HI_SW_REQ && io_wdata_i[1:0] != 2'h0)
        hi_sw_req[io_wdata_i[1:0]] <= io_wdata_i[SEL_SET_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data, registered one cycle after the strobe
  always_comb
  begin
    io_rdata = 8'h00;
    if (lo_word_hit)
      io_rdata = byte_of(io_addr_i[0] ? cur_count[lo_word_chan] :
                         cur_addr[lo_word_chan], lo_ptr);
    else if (hi_word_hit && hi_word_chan == 2'h0)
      io_rdata = byte_of(io_addr_i[1] ? ch4_count : ch4_addr, hi_ptr);
    else if (io_addr_i == LO_STATUS_CMD)
      io_rdata = {pending, lo_tc};
    else if (io_addr_i == HI_STATUS_CMD)
      io_rdata = {hi_sw_req, 5'h00};
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      io_rdata_o <= 8'h00;
    else if (io_rd_i)
      io_rdata_o <= io_rdata;
  end

  ////////////////////////////////////////////////////////////////////////
  // transfer fifo: stalls the engine when the sink backs up
  assign fifo.in_valid = step && moves_data;
  assign fifo.in_data = {active, kind == KIND_WRITE, cur_addr[active]};
  assign fifo.out_ready = xfer_ready_i;

  dma_xfer_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo
  (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .port(fifo.store)
  );

  assign xfer_valid_o = fifo.out_valid;
  assign xfer_chan_o = fifo.out_data[18:17];
  assign xfer_to_memory_o = fifo.out_data[16];
  assign xfer_addr_o = fifo.out_data[15:0];

  // grant pins, polarity from command bit 7
  logic [3:0] grant_raw;
  assign grant_raw = (state != ST_IDLE) ? 4'(1 << active) : 4'h0;
  assign transfer_grant_o = grant_raw ^ {4{!lo_cmd[CMD_GRANT_HIGH]}};
  assign count_exhausted_o = tc_pulse;
  assign extended_write_o = lo_cmd[CMD_EXT_WRITE];
endmodule

// [sim/isa_dma_ctrl_props.sv]
// Purpose: port assertions for isa_dma_ctrl
// Assumes: one clock, reset active low
// Notes: bound from the bench top file
`timescale 1ns/100ps
module isa_dma_ctrl_props
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // io port access
  input wire logic [11:0] io_addr_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [7:0] io_wdata_i,
  input wire logic [7:0] io_rdata_o,
  // peripheral handshake and transfers
  input wire logic [3:0] transfer_request_line_i,
  input wire logic [3:0] transfer_grant_o,
  input wire logic count_exhausted_o,
  input wire logic extended_write_o,
  input wire logic xfer_valid_o,
  input wire logic xfer_ready_i,
  input wire logic [15:0] xfer_addr_o,
  input wire logic [1:0] xfer_chan_o,
  input wire logic xfer_to_memory_o
);
  logic hi_q;
  logic en_q;
  logic [3:0] act;
  // mirror of grant sense and enable, so polarity is known
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      {hi_q, en_q} <= 2'b00;
    else if (io_wr_i && io_addr_i == 12'h00d)
      {hi_q, en_q} <= 2'b00;
    else if (io_wr_i && io_addr_i == 12'h008)
      {hi_q, en_q} <= {io_wdata_i[7], io_wdata_i[2]};
  end
  // grant pins seen as active high
  assign act = hi_q ? transfer_grant_o : ~transfer_grant_o;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);
  ////////////////////////////////////////////////////////////////////////
  AST_ONE_GRANT: assert property ($onehot0(act))
    else $error("more than one grant active");
  AST_NO_GRANT_OFF: assert property
    (!en_q && act == 4'h0 |=> act == 4'h0)
    else $error("grant while disabled");
  AST_EXT_WR: assert property
    (io_wr_i && io_addr_i == 12'h008 |=>
      extended_write_o == $past(io_wdata_i[5]))
    else $error("write style not taken");
  AST_CLEAR: assert property
    (io_wr_i && io_addr_i == 12'h00d |=> !extended_write_o && act == 4'h0)
    else $error("master clear left state");
  AST_RD_HOLD: assert property (!io_rd_i |=> $stable(io_rdata_o))
    else $error("read data moved without read");
  AST_HI_STATUS: assert property
    (io_rd_i && io_addr_i == 12'h0d0 |=> io_rdata_o[4:0] == 5'h00)
    else $error("high status low bits set");
  AST_VALID_CAUSE: assert property
    ($rose(xfer_valid_o) |-> $past(act) != 4'h0)
    else $error("transfer without grant");
  AST_TC_CAUSE: assert property
    (count_exhausted_o |-> $past(act) != 4'h0 ##1 !count_exhausted_o)
    else $error("count pulse without grant");
endmodule

// [sim/dma_periph_model.sv]
// Purpose: peripheral side of the request and grant pins
// Assumes: bench says which channels want service
// Notes: request sense follows the bench, never the dut
`timescale 1ns/100ps
module dma_periph_model
(
  // clock
  input wire logic clk_i,
  // bench control
  input wire logic [3:0] want_i,
  input wire logic req_low_i,
  input wire logic grant_high_i,
  // pins
  input wire logic [3:0] grant_i,
  output logic [3:0] request_o,
  output logic [3:0] seen_o
);
  // idle level is the inactive sense, never a floating value
  assign request_o = want_i ^ {4{req_low_i}};
  // sticky grant seen, dropped when service no longer wanted
  always_ff @(posedge clk_i)
    seen_o <= want_i & (seen_o | (grant_i ^ {4{~grant_high_i}}));
endmodule

// [sim/legacy_isa_dma_controller_bench.sv]
// Purpose: self-checking bench for isa_dma_ctrl
// Assumes: 125 MHz clock, inputs moved 1 ns after the rising edge
// Notes: pops are logged as {chan, to_memory, address}
`timescale 1ns/100ps
module legacy_isa_dma_controller_bench;
  logic clk_i, rstn_i, io_wr_i, io_rd_i, xfer_ready_i, req_low;
  logic count_exhausted_o, extended_write_o, xfer_valid_o, xfer_to_memory_o;
  logic [11:0] io_addr_i;
  logic [7:0] io_wdata_i, io_rdata_o;
  logic [3:0] transfer_request_line_i, transfer_grant_o, want, seen;
  logic [15:0] xfer_addr_o;
  logic [1:0] xfer_chan_o;
  logic [18:0] q[$];
  int fail_count, checked, tcs, i;
  isa_dma_ctrl dut_u
  (
    .clk_i, .rstn_i, .io_addr_i, .io_wr_i, .io_rd_i, .io_wdata_i,
    .io_rdata_o, .transfer_request_line_i, .transfer_grant_o,
    .count_exhausted_o, .extended_write_o, .xfer_valid_o, .xfer_ready_i,
    .xfer_addr_o, .xfer_chan_o, .xfer_to_memory_o
  );
  dma_periph_model peer_u
  (
    .clk_i(clk_i), .want_i(want), .req_low_i(req_low), .grant_high_i(1'b0),
    .grant_i(transfer_grant_o), .request_o(transfer_request_line_i),
    .seen_o(seen)
  );
  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // pops and count pulses logged at the edge that takes them
  always @(posedge clk_i)
  begin
    if (xfer_valid_o && xfer_ready_i)
      q.push_back({xfer_chan_o, xfer_to_memory_o, xfer_addr_o});
    if (count_exhausted_o)
      tcs++;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    if (fail_count == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // one strobe cycle per byte, a free edge before each
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1 {io_wr_i, io_addr_i, io_wdata_i} = {1'b1, a, d};
    @(posedge clk_i);
    #1 io_wr_i = 1'b0;
  endtask
  task automatic wword(input logic [11:0] a, input logic [15:0] w);
    wr(a, w[7:0]);
    wr(a, w[15:8]);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e, string n);
    @(posedge clk_i);
    #1 {io_rd_i, io_addr_i} = {1'b1, a};
    @(posedge clk_i);
    #1 io_rd_i = 1'b0;
    chk(n, e, io_rdata_o);
  endtask
  task automatic wait_q(input int n);
    for (int k = 0; k < 400 && q.size() < n; k++)
      idle(1);
    if (q.size() < n)
    begin
      fail_count++;
      $display("ERROR pops expected %0d seen %0d", n, q.size());
      final_report();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd(12'h008, 8'h00, "status");
    chk("grant", 4'hf, transfer_grant_o);
    rd(12'h100, 8'h00, "unmapped");
    wr(12'h008, 8'h20);
    chk("ext_on", 1, extended_write_o);
    wr(12'h008, 8'h00);
    chk("ext_off", 0, extended_write_o);
  endtask
  // pointer cleared in mid pair, then both pointers walked
  task automatic t_words();
    wr(12'h00c, 8'h00);
    wr(12'h000, 8'h99);
    wr(12'h00c, 8'h00);
    wword(12'h000, 16'h1234);
    rd(12'h000, 8'h34, "addr_lo");
    rd(12'h000, 8'h12, "addr_hi");
    wword(12'h0c0, 16'habcd);
    rd(12'h0c0, 8'hcd, "c4_lo");
    rd(12'h0c0, 8'hab, "c4_hi");
  endtask
  task automatic t_single();
    wword(12'h002, 16'h1000);
    wword(12'h003, 16'h0001);
    wr(12'h00b, 8'h55);
    wr(12'h00a, 8'h01);
    wr(12'h008, 8'h84);
    wr(12'h009, 8'h05);
    for (i = 0; i < 40 && transfer_grant_o === 4'h0; i++)
      idle(1);
    chk("grant_hi", 4'h2, transfer_grant_o);
    wait_q(2);
    chk("pop0", {2'h1, 1'b1, 16'h1000}, q[0]);
    chk("pop1", {2'h1, 1'b1, 16'h1001}, q[1]);
    idle(4);
    rd(12'h008, 8'h02, "tc_set");
    rd(12'h008, 8'h00, "tc_clr");
    rd(12'h002, 8'h00, "reload");
    q.delete();
  endtask
  task automatic t_masks();
    wr(12'h00f, 8'h0f);
    wr(12'h009, 8'h06);
    idle(20);
    chk("masked", 0, q.size());
    rd(12'h008, 8'h40, "pending");
    wr(12'h00d, 8'h00);
    rd(12'h008, 8'h00, "cleared");
    wr(12'h00e, 8'h00);
    wr(12'h008, 8'h04);
    wr(12'h009, 8'h06);
    idle(20);
    rd(12'h008, 8'h04, "verify_tc");
    chk("verify_pop", 0, q.size());
  endtask
  task automatic t_high();
    wr(12'h0d6, 8'hc0);
    wr(12'h0d0, 8'h04);
    wr(12'h0d2, 8'h05);
    wr(12'h0d2, 8'h06);
    rd(12'h0d0, 8'h60, "hi_status");
    chk("hi_pop", 0, q.size());
  endtask
  // block, decrement, read type, low-active request, fifo full
  task automatic t_block();
    int t0;
    t0 = tcs;
    wr(12'h008, 8'h00);
    req_low = 1'b1;
    wr(12'h00f, 8'h0e);
    wword(12'h000, 16'h0010);
    wword(12'h001, 16'h0009);
    wr(12'h00b, 8'ha8);
    xfer_ready_i = 1'b0;
    wr(12'h008, 8'h44);
    want = 4'h1;
    idle(40);
    chk("seen", 1, seen[0]);
    want = 4'h0;
    chk("stall_tc", t0, tcs);
    xfer_ready_i = 1'b1;
    wait_q(10);
    for (i = 0; i < 10; i++)
      chk("pop", {2'h0, 1'b0, 16'h0010 - i[15:0]}, q[i]);
    idle(4);
    chk("block_tc", t0 + 1, tcs);
  endtask
  initial
  begin
    {rstn_i, io_wr_i, io_rd_i, req_low} = 4'h0;
    {io_addr_i, io_wdata_i, want} = 24'h000000;
    xfer_ready_i = 1'b1;
    repeat (4) @(posedge clk_i);
    #1 rstn_i = 1'b1;
    t_reset();
    t_words();
    t_single();
    t_masks();
    t_high();
    t_block();
    final_report();
  end
endmodule
bind isa_dma_ctrl isa_dma_ctrl_props props_u
(
  .clk_i, .rstn_i, .io_addr_i, .io_wr_i, .io_rd_i, .io_wdata_i,
  .io_rdata_o, .transfer_request_line_i, .transfer_grant_o,
  .count_exhausted_o, .extended_write_o, .xfer_valid_o, .xfer_ready_i,
  .xfer_addr_o, .xfer_chan_o, .xfer_to_memory_o
);
